//--- trip_pkg.sv
// Constants and types for the interlock trip output block
package trip_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TRIPS      = 7;
  localparam int unsigned NUM_RELAY      = 4;
  localparam int unsigned PRESS_W        = 16;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned HYST_FRAC      = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_BASE       = 8'h00;
  localparam logic [7:0]  THR_BASE       = 8'h20;
  localparam logic [7:0]  HYST_ADDR      = 8'h40;
  localparam logic [7:0]  STATUS_ADDR    = 8'h44;

  // Config register fields
  localparam int unsigned STATE_LSB      = 0;
  localparam int unsigned POLICY_LSB     = 2;
  localparam int unsigned SOURCE_LSB     = 4;
  localparam int unsigned DIR_BIT        = 8;

  // Status register fields
  localparam int unsigned STAT_VAR_BIT   = 8;
  localparam int unsigned STAT_HB_BIT    = 9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] THR_RESET      = 16'h0000;
  localparam logic [15:0] HYST_RESET     = 16'h0180;
  localparam logic [15:0] HYST_UNITY     = 16'h0100;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ----------------------------------------------------------------
  // Heartbeat timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ        = 125_000;
  localparam int unsigned HB_PERIOD_MS   = 1000;
  localparam int unsigned HB_CYCLES_DEF  = HB_PERIOD_MS * CLK_KHZ;
  localparam int unsigned HB_CNT_W       = 27;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_NORMAL, ST_INHIBIT, ST_OVERRIDE, ST_SPARE
  } trip_state_e;

  typedef enum logic [1:0] {
    PU_LAST, PU_RESET, PU_INHIBIT, PU_OVERRIDE
  } power_policy_e;

  typedef enum logic [3:0] {
    SRC_NONE, SRC_IG1_PRESS, SRC_MODULE1, SRC_BAKE_Z1,
    SRC_MODULE2, SRC_IG1_DUAL, SRC_IG1_ON, SRC_IG1_DEGAS,
    SRC_BAKE_Z2, SRC_TIMER1, SRC_TIMER2, SRC_HEARTBEAT,
    SRC_IG2_PRESS, SRC_IG2_DUAL, SRC_IG2_ON, SRC_IG2_DEGAS
  } trip_source_e;

endpackage : trip_pkg

//--- interlock_trip_outputs.sv
// Seven trip outputs with source selection, hysteresis and AXI4-Lite registers
//
// Overview of operation
// R01: Seven trips; 1-4 relay, 5-7 open collector
// R02: State normal, inhibit off, override on
// R03: Last-setting policy restores saved state
// R04: Reset policy clears inhibit and override
// R05: Inhibit or override policy forces start state
// R06: Source none leaves trip undriven
// R07: Ion gauge one pressure compared to threshold
// R08: Module one or two reading compared
// R09: Dual-gauge combined reading compared
// R10: Gauge on or degas status followed directly
// R11: Bake-out zone heater control followed
// R12: Timer on period drives trip exactly
// R13: Heartbeat toggles each second, trips 5-7
// R14: Ion gauge two sources need two-gauge variant
// R15: Direction selects below or above threshold
// R16: Each trip holds own switch threshold
// R17: Below direction off threshold is on threshold times hysteresis
// R18: One hysteresis factor shared by all trips
// R19: Above direction turns off below threshold/hysteresis
// R20: Comparator holds level between crossings
`timescale 1ns/10ps

module interlock_trip_outputs
  import trip_pkg::*;
#(
  parameter int unsigned HEARTBEAT_CYCLES = trip_pkg::HB_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // AXI4-Lite write address
  input  wire logic [trip_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [trip_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [trip_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [trip_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Power-up straps and retained settings
  input  wire logic                          two_gauge_variant,
  input  wire logic [2*trip_pkg::NUM_TRIPS-1:0] saved_state,
  input  wire logic [2*trip_pkg::NUM_TRIPS-1:0] saved_policy,
  output logic [2*trip_pkg::NUM_TRIPS-1:0]   retain_state,
  output logic [2*trip_pkg::NUM_TRIPS-1:0]   retain_policy,
  // Gauge readings
  input  wire logic [trip_pkg::PRESS_W-1:0]  ion_gauge_one_press,
  input  wire logic [trip_pkg::PRESS_W-1:0]  ion_gauge_one_dual,
  input  wire logic [trip_pkg::PRESS_W-1:0]  ion_gauge_two_press,
  input  wire logic [trip_pkg::PRESS_W-1:0]  ion_gauge_two_dual,
  input  wire logic [trip_pkg::PRESS_W-1:0]  module_one_press,
  input  wire logic [trip_pkg::PRESS_W-1:0]  module_two_press,
  // Status sources
  input  wire logic                          ion_gauge_one_on,
  input  wire logic                          ion_gauge_one_degas,
  input  wire logic                          ion_gauge_two_on,
  input  wire logic                          ion_gauge_two_degas,
  input  wire logic                          bake_zone_one_heat,
  input  wire logic                          bake_zone_two_heat,
  input  wire logic                          timer_one_on,
  input  wire logic                          timer_two_on,
  // Trip outputs
  output logic [3:0]                         relay_trip,
  output logic [2:0]                         oc_trip
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Trip index of a config or threshold address, 7 when none
  function automatic logic [2:0] trip_index(input logic [7:0] addr,
                                            input logic [7:0] base);
    logic [7:0] off;
    off = addr - base;
    if (addr >= base && off[1:0] == 2'b00 && off[7:2] < 6'(NUM_TRIPS)) begin
      return off[4:2];
    end
    return 3'd7;
  endfunction : trip_index

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  trip_state_e    state_reg  [NUM_TRIPS];
  power_policy_e  policy_reg [NUM_TRIPS];
  trip_source_e   source_reg [NUM_TRIPS];
  logic           dir_reg    [NUM_TRIPS];
  logic [15:0]    thr_reg    [NUM_TRIPS];
  logic [15:0]    hyst_reg;
  logic [6:0]     cmp_reg;
  logic [6:0]     trip_reg;
  logic           init_done_reg;
  logic           variant_reg;
  logic           hb_reg;
  logic [HB_CNT_W-1:0] hb_cnt_reg;

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic [7:0]     awaddr_reg;
  logic           aw_have_reg;
  logic [31:0]    wdata_reg;
  logic [3:0]     wstrb_reg;
  logic           w_have_reg;
  logic           bvalid_reg;
  logic [1:0]     bresp_reg;
  logic           wr_fire;
  logic [2:0]     wr_cfg_idx;
  logic [2:0]     wr_thr_idx;
  logic           wr_hyst;
  logic           wr_hit;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  assign wr_fire    = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_cfg_idx = trip_index(awaddr_reg, CFG_BASE);
  assign wr_thr_idx = trip_index(awaddr_reg, THR_BASE);
  assign wr_hyst    = (awaddr_reg == HYST_ADDR);
  assign wr_hit     = (wr_cfg_idx != 3'd7) || (wr_thr_idx != 3'd7) ||
                      wr_hyst || (awaddr_reg == STATUS_ADDR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_have_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-up load and config registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_done_reg <= 1'b0;
      variant_reg   <= 1'b0;
    end else if (!init_done_reg) begin
      init_done_reg <= 1'b1;
      variant_reg   <= two_gauge_variant;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_TRIPS; i++) begin
        state_reg[i]  <= ST_NORMAL;
        policy_reg[i] <= PU_RESET;
        source_reg[i] <= SRC_NONE;
        dir_reg[i]    <= 1'b0;
      end
    end else if (!init_done_reg) begin
      for (int i = 0; i < NUM_TRIPS; i++) begin
        policy_reg[i] <= power_policy_e'(saved_policy[2*i +: 2]);
        unique case (power_policy_e'(saved_policy[2*i +: 2]))
          PU_LAST:     state_reg[i] <= trip_state_e'(saved_state[2*i +: 2]); // R03
          PU_RESET:    state_reg[i] <= ST_NORMAL;                            // R04
          PU_INHIBIT:  state_reg[i] <= ST_INHIBIT;                           // R05
          PU_OVERRIDE: state_reg[i] <= ST_OVERRIDE;                          // R05
        endcase
      end
    end else if (wr_fire && wr_cfg_idx != 3'd7) begin
      logic [31:0] v;
      v = lane_merge({23'h0, dir_reg[wr_cfg_idx], source_reg[wr_cfg_idx],
                      policy_reg[wr_cfg_idx], state_reg[wr_cfg_idx]},
                     wdata_reg, wstrb_reg);
      state_reg[wr_cfg_idx]  <= trip_state_e'(v[STATE_LSB +: 2]);
      policy_reg[wr_cfg_idx] <= power_policy_e'(v[POLICY_LSB +: 2]);
      source_reg[wr_cfg_idx] <= trip_source_e'(v[SOURCE_LSB +: 4]);
      dir_reg[wr_cfg_idx]    <= v[DIR_BIT];                                  // R15
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_TRIPS; i++) begin
        thr_reg[i] <= THR_RESET;
      end
      hyst_reg <= HYST_RESET;
    end else if (wr_fire && wr_thr_idx != 3'd7) begin
      thr_reg[wr_thr_idx] <= 16'(lane_merge({16'h0, thr_reg[wr_thr_idx]},
                                            wdata_reg, wstrb_reg));          // R16
    end else if (wr_fire && wr_hyst) begin
      hyst_reg <= 16'(lane_merge({16'h0, hyst_reg}, wdata_reg, wstrb_reg));  // R18
    end
  end

  // ----------------------------------------------------------------
  // Heartbeat
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hb_cnt_reg <= '0;
      hb_reg     <= 1'b0;
    end else if (hb_cnt_reg >= HB_CNT_W'(HEARTBEAT_CYCLES - 1)) begin
      hb_cnt_reg <= '0;
      hb_reg     <= !hb_reg;                                                 // R13
    end else begin
      hb_cnt_reg <= hb_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Per-trip source selection and hysteretic compare
  // ----------------------------------------------------------------
  logic [15:0] hyst_eff;
  // Factor below unity would put off point on the wrong side
  assign hyst_eff = (hyst_reg < HYST_UNITY) ? HYST_UNITY : hyst_reg;
  for (genvar t = 0; t < NUM_TRIPS; t++) begin : g_trip
    logic [15:0] val;
    logic        is_gauge;
    logic        stat;
    logic        src_lvl;
    logic        on_c;
    logic        off_c;
    logic [31:0] val_h;
    logic [31:0] thr_h;
    logic        trip_next;

    always_comb begin
      val      = 16'h0000;
      is_gauge = 1'b0;
      stat     = 1'b0;
      unique case (source_reg[t])
        SRC_NONE:      stat = 1'b0;                                          // R06
        SRC_IG1_PRESS: begin val = ion_gauge_one_press; is_gauge = 1'b1; end // R07
        SRC_MODULE1:   begin val = module_one_press; is_gauge = 1'b1; end    // R08
        SRC_MODULE2:   begin val = module_two_press; is_gauge = 1'b1; end    // R08
        SRC_IG1_DUAL:  begin val = ion_gauge_one_dual; is_gauge = 1'b1; end  // R09
        SRC_IG2_PRESS: begin
          val      = ion_gauge_two_press;
          is_gauge = variant_reg;                                            // R14
        end
        SRC_IG2_DUAL:  begin
          val      = ion_gauge_two_dual;
          is_gauge = variant_reg;                                            // R14
        end
        SRC_IG1_ON:    stat = ion_gauge_one_on;                              // R10
        SRC_IG1_DEGAS: stat = ion_gauge_one_degas;                           // R10
        SRC_IG2_ON:    stat = variant_reg && ion_gauge_two_on;               // R10
        SRC_IG2_DEGAS: stat = variant_reg && ion_gauge_two_degas;            // R10
        SRC_BAKE_Z1:   stat = bake_zone_one_heat;                            // R11
        SRC_BAKE_Z2:   stat = bake_zone_two_heat;                            // R11
        SRC_TIMER1:    stat = timer_one_on;                                  // R12
        SRC_TIMER2:    stat = timer_two_on;                                  // R12
        SRC_HEARTBEAT: stat = (t >= NUM_RELAY) && hb_reg;                    // R13
      endcase
    end

    assign val_h = val * hyst_eff;
    assign thr_h = thr_reg[t] * hyst_eff;
    always_comb begin
      if (dir_reg[t]) begin
        on_c  = val > thr_reg[t];                                            // R15
        off_c = val_h < {8'h00, thr_reg[t], 8'h00};                          // R19
      end else begin
        on_c  = val < thr_reg[t];                                            // R15
        off_c = {8'h00, val, 8'h00} > thr_h;                                 // R17
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cmp_reg[t] <= 1'b0;
      end else if (!is_gauge) begin
        cmp_reg[t] <= 1'b0;
      end else if (on_c) begin
        cmp_reg[t] <= 1'b1;
      end else if (off_c) begin
        cmp_reg[t] <= 1'b0;
      end                                                                    // R20
    end
    assign src_lvl = is_gauge ? cmp_reg[t] : stat;
    always_comb begin
      unique case (state_reg[t])
        ST_INHIBIT:  trip_next = 1'b0;                                       // R02
        ST_OVERRIDE: trip_next = 1'b1;                                       // R02
        default:     trip_next = src_lvl;                                    // R02
      endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        trip_reg[t] <= 1'b0;
      end else begin
        trip_reg[t] <= init_done_reg && trip_next;
      end
    end

    assign retain_state[2*t +: 2]  = state_reg[t];
    assign retain_policy[2*t +: 2] = policy_reg[t];
  end

  assign relay_trip = trip_reg[NUM_RELAY-1:0];                               // R01
  assign oc_trip    = trip_reg[NUM_TRIPS-1:NUM_RELAY];                       // R01

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [2:0]  rd_cfg_idx;
  logic [2:0]  rd_thr_idx;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_cfg_idx    = trip_index(s_axi_araddr, CFG_BASE);
  assign rd_thr_idx    = trip_index(s_axi_araddr, THR_BASE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      if (rd_cfg_idx != 3'd7) begin
        rdata_reg <= {23'h0, dir_reg[rd_cfg_idx], source_reg[rd_cfg_idx],
                      policy_reg[rd_cfg_idx], state_reg[rd_cfg_idx]};
      end else if (rd_thr_idx != 3'd7) begin
        rdata_reg <= {16'h0000, thr_reg[rd_thr_idx]};
      end else if (s_axi_araddr == HYST_ADDR) begin
        rdata_reg <= {16'h0000, hyst_reg};
      end else if (s_axi_araddr == STATUS_ADDR) begin
        rdata_reg <= 32'({hb_reg, variant_reg, 1'b0, trip_reg});
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : interlock_trip_outputs

//--- trip_checker.sv
// Assertion checker for the trip output block
`timescale 1ns/10ps
module trip_checker
  import trip_pkg::*;
(
  input wire logic [0:0]                        clk,
  input wire logic [0:0]                        reset_n,
  input wire logic [2*trip_pkg::NUM_TRIPS-1:0]  saved_state,
  input wire logic [2*trip_pkg::NUM_TRIPS-1:0]  saved_policy,
  input wire logic [2*trip_pkg::NUM_TRIPS-1:0]  retain_state,
  input wire logic [3:0]                        relay_trip,
  input wire logic [2:0]                        oc_trip
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_PU_LAST: assert property ($rose(reset_n) && saved_policy[1:0] == PU_LAST
    |=> retain_state[1:0] == $past(saved_state[1:0])) else $error("state not restored");
  AST_PU_RESET: assert property ($rose(reset_n) && saved_policy[1:0] == PU_RESET
    |=> retain_state[1:0] == ST_NORMAL) else $error("state not cleared");
  AST_PU_INH: assert property ($rose(reset_n) && saved_policy[1:0] == PU_INHIBIT
    |-> ##1 retain_state[1:0] == ST_INHIBIT) else $error("no inhibit at power up");
  AST_PU_OVR: assert property ($rose(reset_n) && saved_policy[1:0] == PU_OVERRIDE
    |=> (retain_state[1:0] == ST_OVERRIDE) [*2]) else $error("no override at power up");
  AST_INH_RELAY: assert property ((retain_state[1:0] == ST_INHIBIT) [*2]
    |-> !relay_trip[0]) else $error("inhibited relay on");
  AST_OVR_RELAY: assert property (retain_state[1:0] == ST_OVERRIDE
    && $past(retain_state[1:0]) == ST_OVERRIDE |-> relay_trip[0]) else $error("relay off");
  AST_INH_OC: assert property ($stable(retain_state[9:8])
    && retain_state[9:8] == ST_INHIBIT |-> !oc_trip[0]) else $error("inhibited output on");
  AST_OVR_OC: assert property ((retain_state[9:8] == ST_OVERRIDE) [*2]
    |-> oc_trip[0]) else $error("override output off");
endmodule : trip_checker

bind interlock_trip_outputs trip_checker u_trip_checker (.clk(clk), .reset_n(reset_n),
  .saved_state(saved_state), .saved_policy(saved_policy), .retain_state(retain_state),
  .relay_trip(relay_trip), .oc_trip(oc_trip));

//--- trip_load.sv
// Behavioural model of the relay and open-collector loads on the trips
`timescale 1ns/10ps
module trip_load (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Trip drive
  input  wire logic [3:0] relay_trip,
  input  wire logic [2:0] oc_trip,
  // Load condition, trip one in bit 0
  output logic [6:0]      energized
);
  // Loads pick up one cycle after drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) energized <= 7'h00;
    else energized <= {oc_trip, relay_trip};
  end
endmodule : trip_load

//--- testbench.sv
// Self-checking testbench for the trip output block
`timescale 1ns/10ps
module testbench;
  import trip_pkg::*;
  logic        clk, reset_n, two_gauge_variant, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, stat;
  logic [31:0] wdata, rdata;
  logic [15:0] gv;
  logic [5:0]  gsel;
  logic [13:0] saved_policy, rpol;
  logic [6:0]  energized;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  relay_trip;
  logic [2:0]  oc_trip;
  int          err_total, comparisons, cyc;

  interlock_trip_outputs #(.HEARTBEAT_CYCLES(10)) DUT (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .two_gauge_variant(two_gauge_variant), .saved_state({12'h000, ST_OVERRIDE}),
    .saved_policy(saved_policy), .retain_state(), .retain_policy(rpol),
    .ion_gauge_one_press(gsel[0] ? gv : ~gv), .ion_gauge_one_dual(gsel[1] ? gv : ~gv),
    .ion_gauge_two_press(gsel[2] ? gv : ~gv), .ion_gauge_two_dual(gsel[3] ? gv : ~gv),
    .module_one_press(gsel[4] ? gv : ~gv), .module_two_press(gsel[5] ? gv : ~gv),
    .ion_gauge_one_on(stat[0]), .ion_gauge_one_degas(stat[1]), .ion_gauge_two_on(stat[2]),
    .ion_gauge_two_degas(stat[3]), .bake_zone_one_heat(stat[4]),
    .bake_zone_two_heat(stat[5]), .timer_one_on(stat[6]), .timer_two_on(stat[7]),
    .relay_trip(relay_trip), .oc_trip(oc_trip));
  trip_load LOAD (.clk(clk), .reset_n(reset_n), .relay_trip(relay_trip), .oc_trip(oc_trip),
    .energized(energized));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tchk(input string n, input int i, input logic e);
    repeat (4) @(posedge clk);
    chk(n, {31'h0, e}, {31'h0, energized[i]});
  endtask : tchk
  function automatic logic [31:0] cf(logic [1:0] s, logic [3:0] src, logic dr);
    return {23'h0, dr, src, PU_RESET, s};
  endfunction : cf
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rst(input logic [1:0] p);
    @(posedge clk);
    reset_n <= 1'b0;
    saved_policy <= {12'h000, p};
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst
  task automatic t_power;
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  e[4];
    e = '{ST_OVERRIDE, ST_NORMAL, ST_INHIBIT, ST_OVERRIDE};
    for (int p = 0; p < 4; p++) begin
      rst(2'(p));
      rd(CFG_BASE, d, r);
      chk("power_up_state", {30'h0, e[p]}, {30'h0, d[1:0]});
      chk("power_up_policy", 32'(p), {18'h0, rpol});
    end
    rd(8'h80, d, r);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h80, 32'h0000_0000);
    chk("unmapped_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, bresp});
  endtask : t_power
  task automatic t_state;
    logic [1:0] st[4];
    st = '{ST_NORMAL, ST_INHIBIT, ST_OVERRIDE, ST_SPARE};
    @(posedge clk);
    stat <= 8'hff;
    wr(CFG_BASE, cf(ST_NORMAL, 4'h0, 1'b0));
    tchk("unused_trip", 0, 1'b0);
    for (int t = 0; t < 5; t += 4)
      for (int k = 0; k < 4; k++) begin
        wr(CFG_BASE + 8'(4 * t), cf(st[k], 4'h6, 1'b0));
        tchk("forced_state", t, k != 1);
      end
  endtask : t_state
  task automatic t_status;
    logic [3:0] src[8];
    int         b[8];
    src = '{4'h6, 4'h7, 4'h3, 4'h8, 4'h9, 4'ha, 4'he, 4'hf};
    b = '{0, 1, 4, 5, 6, 7, 2, 3};
    for (int k = 0; k < 8; k++) begin
      wr(CFG_BASE + 8'h08, cf(ST_NORMAL, src[k], 1'b0));
      stat <= 8'h01 << b[k];
      tchk("status_on", 2, 1'b1);
      stat <= ~(8'h01 << b[k]);
      tchk("status_off", 2, 1'b0);
    end
  endtask : t_status
  task automatic gseq(input int i, input logic [3:0] s, input logic dr, input logic [15:0] th,
                      input logic [15:0] v[5], input logic [4:0] ex, input logic [5:0] m);
    gsel <= m;
    wr(THR_BASE + 8'(4 * i), {16'h0000, th});
    wr(CFG_BASE + 8'(4 * i), cf(ST_NORMAL, s, dr));
    for (int k = 0; k < 5; k++) begin
      gv <= v[k];
      tchk("gauge_trip", i, ex[k]);
    end
  endtask : gseq
  task automatic t_gauge;
    gseq(0, 4'h1, 1'b0, 16'h0100,
         '{16'h00ff, 16'h0150, 16'h0181, 16'h0150, 16'h00ff}, 5'h13, 6'h01);
    wr(HYST_ADDR, 32'h0000_0200);
    gseq(1, 4'h2, 1'b1, 16'h0300,
         '{16'h0301, 16'h0200, 16'h017f, 16'h0200, 16'h0301}, 5'h13, 6'h10);
    gseq(0, 4'h5, 1'b0, 16'h0100,
         '{16'h00ff, 16'h01f0, 16'h0201, 16'h01f0, 16'h00ff}, 5'h13, 6'h02);
    gseq(2, 4'hc, 1'b0, 16'h0100, '{5{16'h0010}}, 5'h00, 6'h04);
    two_gauge_variant <= 1'b1;
    rst(2'h1);
    gseq(2, 4'hd, 1'b0, 16'h0100, '{5{16'h0010}}, 5'h1f, 6'h08);
    gseq(3, 4'h4, 1'b0, 16'h0100,
         '{16'h00ff, 16'h0150, 16'h0181, 16'h0150, 16'h00ff}, 5'h13, 6'h20);
  endtask : t_gauge
  task automatic t_beat;
    logic h0;
    wr(CFG_BASE, cf(ST_NORMAL, 4'hb, 1'b0));
    wr(CFG_BASE + 8'h10, cf(ST_NORMAL, 4'hb, 1'b0));
    repeat (4) @(posedge clk);
    h0 = energized[4];
    repeat (10) @(posedge clk);
    chk("beat_toggle", {31'h0, ~h0}, {31'h0, energized[4]});
    chk("beat_relay", 32'h0, {31'h0, energized[0]});
  endtask : t_beat
  task automatic end_of_test;
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {reset_n, two_gauge_variant, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {gsel, awaddr, araddr, stat, saved_policy} = 44'h000_0000_0000;
    wdata = 32'h0000_0000;
    gv = 16'h0200;
    t_power();
    t_state();
    t_beat();
    t_gauge();
    t_status();
    end_of_test();
  end
  // Cuts a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
endmodule : testbench
